/* File: core/alt_mode_switch_config_regs.sv */
// Configuration and status registers of a Type-C alternate-mode redriving switch.
// Assumes a byte register port decoded by a serial slave outside, snooped sink
// writes presented as one-cycle strobes, and straps steady around reset.
//
// Notes on behaviour
// - Select 00 off, 10 four lanes, 11 two+USB
// - Lane select resets to USB-only 01
// - Override clear: equalization follows sampled straps
// - Override set: equalization follows register fields
// - Force bit makes hot-plug input high
// - Swap bit moves hot-plug to alternate pin
// - Lanes 0,1 equalization in one register
// - Lanes 2,3 equalization at 0x11, reset to strap level
// - Override clear: fields read back strap levels
// - Override set: writes set applied equalization
// - Capture snooped power-state writes, bits 6:5
// - Snooping on: power state gates lanes
// - Capture snooped lane-count writes, bits 4:0
// - Snooping on: enable only counted lanes
// - Snooping off: select mask and per-lane disables decide
// - Select upper bit falling clears power state
// - Select upper bit falling clears lane count
// - Snoop disable resets to zero, on
// - Lane disable bit: 0 on, 1 off
`default_nettype none
module alt_mode_switch_config_regs
   import alt_mode_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Register port from the serial slave
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_write_in,
   input  wire logic        reg_read_in,
   output logic      [7:0]  reg_rdata_out,
   // Snooped sink configuration writes
   input  wire logic        snoop_write_in,
   input  wire logic [19:0] snoop_addr_in,
   input  wire logic [7:0]  snoop_data_in,
   // Straps and hot-plug pins
   input  wire logic [1:0]  display_eq_straps_in,
   input  wire logic [1:0]  superspeed_eq_straps_in,
   input  wire logic [1:0]  usb_rx_eq_straps_in,
   input  wire logic        hotplug_pin_a_in,
   input  wire logic        hotplug_pin_b_in,
   // Controls to the datapath
   output logic      [3:0]  dp_lane_en_out,
   output logic             usb_path_en_out,
   output logic             orientation_flip_select_out,
   output logic             hotplug_input_out,
   output logic      [15:0] lane_eq_level_out,
   output logic      [1:0]  superspeed_eq_straps_out,
   output logic      [1:0]  usb_rx_eq_straps_out
);
   import alt_mode_pkg::*;

   typedef struct packed {
      logic [1:0]  cfg;
      logic        flip;
      logic        hpd_force;
      logic        eq_ovr;
      logic        hpd_swap;
      logic [15:0] eq;
      logic [1:0]  pwr;
      logic [4:0]  cnt;
      logic        snoop_off;
      logic [3:0]  lane_off;
      logic [7:0]  rdata;
      logic [3:0]  lane_en;
      logic        usb_en;
      logic        flip_o;
      logic        hpd_o;
      logic        straps_taken;
      logic [1:0]  dp_strap;
      logic [1:0]  ss_strap;
      logic [1:0]  usb_strap;
   } state_type;

   state_type  s;
   state_type  next_s;
   lane_ctl_if ctl ();

   lane_enable_decode u_decode (
      .ctl (ctl.decoder)
   );

   assign ctl.cfg       = s.cfg;
   assign ctl.snoop_off = s.snoop_off;
   assign ctl.lane_off  = s.lane_off;
   assign ctl.pwr       = s.pwr;
   assign ctl.cnt       = s.cnt;

   logic            wr_gen;
   logic            wr_eq01;
   logic            wr_eq23;
   logic            wr_lane;
   logic            pwr_hit;
   logic            cnt_hit;
   logic [EQ_W-1:0] strap_level;

   assign wr_gen      = reg_write_in && (reg_addr_in == GEN_CTRL_ADDR);
   assign wr_eq01     = reg_write_in && (reg_addr_in == LANE01_EQ_ADDR);
   assign wr_eq23     = reg_write_in && (reg_addr_in == LANE23_EQ_ADDR);
   assign wr_lane     = reg_write_in && (reg_addr_in == LANE_CTRL_ADDR);
   assign pwr_hit     = snoop_write_in && (snoop_addr_in == PWR_STATE_ADDR);
   assign cnt_hit     = snoop_write_in && (snoop_addr_in == LANE_COUNT_ADDR);
   // Four-level straps are seen here as two bits, widened to the field
   assign strap_level = {s.dp_strap, EQ_STRAP_PAD};

   always_comb begin
      next_s = s;
      // Straps are taken once, in the first cycle after reset release
      if (!s.straps_taken) begin
         next_s.straps_taken = 1'b1;
         next_s.dp_strap     = display_eq_straps_in;
         next_s.ss_strap     = superspeed_eq_straps_in;
         next_s.usb_strap    = usb_rx_eq_straps_in;
      end
      if (wr_gen) begin
         next_s.cfg       = reg_wdata_in[GC_CFG_MSB:GC_CFG_LSB];
         next_s.flip      = reg_wdata_in[GC_FLIP_BIT];
         next_s.hpd_force = reg_wdata_in[GC_HPD_FORCE_BIT];
         next_s.eq_ovr    = reg_wdata_in[GC_EQ_OVR_BIT];
         next_s.hpd_swap  = reg_wdata_in[GC_HPD_SWAP_BIT];
      end
      if (wr_lane) begin
         next_s.snoop_off = reg_wdata_in[SNOOP_OFF_BIT];
         next_s.lane_off  = reg_wdata_in[LANE_OFF_MSB:0];
      end
      // Equalization fields: straps own them unless software overrides
      if (!s.eq_ovr) begin
         next_s.eq = {LANES{strap_level}};
      end else begin
         if (wr_eq01) begin
            next_s.eq[7:0] = reg_wdata_in;
         end
         if (wr_eq23) begin
            next_s.eq[15:8] = reg_wdata_in;
         end
      end
      // Leaving a display mode drops stale captures; a snoop in the same
      // cycle still lands, so no sink write is lost
      if (s.cfg[GC_CFG_MSB] && !next_s.cfg[GC_CFG_MSB]) begin
         next_s.pwr = '0;
         next_s.cnt = '0;
      end
      if (pwr_hit) begin
         next_s.pwr = snoop_data_in[1:0];
      end
      if (cnt_hit) begin
         next_s.cnt = snoop_data_in[4:0];
      end
      if (reg_read_in) begin
         case (reg_addr_in)
            GEN_CTRL_ADDR:  next_s.rdata = {2'h0, s.hpd_swap, s.eq_ovr, s.hpd_force,
                                            s.flip, s.cfg};
            LANE01_EQ_ADDR: next_s.rdata = s.eq[7:0];
            LANE23_EQ_ADDR: next_s.rdata = s.eq[15:8];
            SNOOP_CAP_ADDR: next_s.rdata = {1'b0, s.pwr, s.cnt};
            LANE_CTRL_ADDR: next_s.rdata = {s.snoop_off, 3'h0, s.lane_off};
            default:        next_s.rdata = 8'h00;
         endcase
      end
      next_s.lane_en = ctl.lane_en;
      next_s.usb_en  = (s.cfg == CFG_USB_ONLY) || (s.cfg == CFG_DP_TWO_USB);
      next_s.flip_o  = s.flip;
      if (s.hpd_force) begin
         next_s.hpd_o = 1'b1;
      end else if (s.hpd_swap) begin
         next_s.hpd_o = hotplug_pin_b_in;
      end else begin
         next_s.hpd_o = hotplug_pin_a_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s     <= '0;
         s.cfg <= GEN_CTRL_CFG_RST;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_out               = s.rdata;
   assign dp_lane_en_out              = s.lane_en;
   assign usb_path_en_out             = s.usb_en;
   assign orientation_flip_select_out = s.flip_o;
   assign hotplug_input_out           = s.hpd_o;
   assign lane_eq_level_out           = s.eq;
   assign superspeed_eq_straps_out    = s.ss_strap;
   assign usb_rx_eq_straps_out        = s.usb_strap;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence override_eq01_write;
      s.eq_ovr && wr_eq01;
   endsequence

   sequence leave_display_mode;
      s.cfg[GC_CFG_MSB] && wr_gen && !reg_wdata_in[GC_CFG_MSB] && !pwr_hit && !cnt_hit;
   endsequence

   reset_select_value_a : assert property ($past(rst_in) |-> s.cfg == CFG_USB_ONLY)
      else $error("lane select not USB-only after reset");
   // Lane and path enables are registered once, so they trail the select by one edge
   all_off_mode_a : assert property ((s.cfg == CFG_ALL_OFF) |=>
         (!usb_path_en_out && dp_lane_en_out == 4'h0))
      else $error("paths enabled in all-off configuration");
   strap_eq_follow_a : assert property ((!s.eq_ovr && s.straps_taken) |=>
         lane_eq_level_out == {4{$past(s.dp_strap), 2'h0}})
      else $error("equalization not following straps");
   override_write_a : assert property (override_eq01_write |=>
         lane_eq_level_out[7:0] == $past(reg_wdata_in))
      else $error("override write not applied");
   hotplug_force_a : assert property (s.hpd_force |=> hotplug_input_out)
      else $error("forced hot-plug input not high");
   hotplug_swap_a : assert property ((!s.hpd_force && s.hpd_swap) |=>
         hotplug_input_out == $past(hotplug_pin_b_in))
      else $error("swapped hot-plug pin not used");
   power_capture_a : assert property ((pwr_hit && !wr_gen) |=>
         s.pwr == $past(snoop_data_in[1:0]))
      else $error("power-state snoop not captured");
   capture_clear_a : assert property (leave_display_mode |=>
         (s.pwr == 2'h0 && s.cnt == 5'h0))
      else $error("captures not cleared on select fall");
   snoop_off_lanes_a : assert property ((s.snoop_off && s.cfg == CFG_DP_FOUR) |=>
         dp_lane_en_out == ~$past(s.lane_off))
      else $error("lane disables not honoured");
   counted_lanes_a : assert property ((!s.snoop_off && s.cfg == CFG_DP_FOUR
         && s.pwr == PWR_ACTIVE && s.cnt == 5'h2) |=> dp_lane_en_out == 4'h3)
      else $error("lane count not honoured");
   reserved_read_a : assert property ((reg_read_in && reg_addr_in == SNOOP_CAP_ADDR) |=>
         !reg_rdata_out[7])
      else $error("reserved bit reads one");

   // Equalization ownership: straps until override, then software alone
   sequence strap_owned;
      !s.eq_ovr && $past(!s.eq_ovr) && $past(s.straps_taken);
   endsequence

   sequence override_eq23_write;
      s.eq_ovr && wr_eq23;
   endsequence

   override_eq23_a : assert property (override_eq23_write |=>
         lane_eq_level_out[15:8] == $past(reg_wdata_in))
      else $error("override write to lanes 2,3 not applied");

   eq_hold_a : assert property ((s.eq_ovr && !wr_eq01 && !wr_eq23) |=>
         $stable(lane_eq_level_out))
      else $error("overridden equalization moved without a write");

   strap_readback_a : assert property ((strap_owned ##0 reg_read_in
         && reg_addr_in == LANE01_EQ_ADDR) |=> reg_rdata_out == {2{s.dp_strap, 2'h0}})
      else $error("equalization field not reading strap level");

   strap_hold_a : assert property (s.straps_taken |=>
         ($stable(superspeed_eq_straps_out) && $stable(usb_rx_eq_straps_out)))
      else $error("captured straps changed after sampling");

   // Snoop captures
   count_capture_a : assert property ((cnt_hit && !wr_gen) |=>
         s.cnt == $past(snoop_data_in[4:0]))
      else $error("lane-count snoop not captured");

   capture_steady_a : assert property ((!pwr_hit && !cnt_hit && !wr_gen) |=>
         ($stable(s.pwr) && $stable(s.cnt)))
      else $error("captures changed without a snoop");

   // Lane and USB path enables
   power_gate_a : assert property ((!s.snoop_off && s.pwr != PWR_ACTIVE) |=>
         dp_lane_en_out == 4'h0)
      else $error("lanes on without active power state");

   lane_off_ignored_a : assert property ((!s.snoop_off && s.cfg == CFG_DP_FOUR
         && s.pwr == PWR_ACTIVE && s.cnt >= 5'h4) |=> dp_lane_en_out == 4'hF)
      else $error("lane disables acted while snooping");

   usb_path_a : assert property ((s.cfg == CFG_USB_ONLY || s.cfg == CFG_DP_TWO_USB) |=>
         usb_path_en_out)
      else $error("USB path off in a USB configuration");

   two_lane_mask_a : assert property ((s.cfg == CFG_DP_TWO_USB) |=>
         dp_lane_en_out[3:2] == 2'h0)
      else $error("upper lanes on in two-lane configuration");

   usb_only_lanes_a : assert property ((s.cfg == CFG_USB_ONLY) |=>
         (dp_lane_en_out == 4'h0 && usb_path_en_out))
      else $error("wrong enables in USB-only configuration");

   // Control register writes
   general_write_a : assert property (wr_gen |=>
         (s.cfg == $past(reg_wdata_in[GC_CFG_MSB:GC_CFG_LSB])
          && s.eq_ovr == $past(reg_wdata_in[GC_EQ_OVR_BIT])))
      else $error("general control write not taken");

   lane_write_a : assert property (wr_lane |=>
         s.snoop_off == $past(reg_wdata_in[SNOOP_OFF_BIT]))
      else $error("snoop disable write not taken");

   snoop_reset_a : assert property ($past(rst_in) |->
         (!s.snoop_off && s.lane_off == 4'h0))
      else $error("lane control not cleared by reset");

   flip_follow_a : assert property (wr_gen |=> ##1
         orientation_flip_select_out == $past(reg_wdata_in[GC_FLIP_BIT], 2))
      else $error("flip select not following register");

   // Hot-plug input
   hotplug_default_a : assert property ((!s.hpd_force && !s.hpd_swap) |=>
         hotplug_input_out == $past(hotplug_pin_a_in))
      else $error("default hot-plug pin not used");

   // Read port
   read_stands_a : assert property (!reg_read_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");

   unmapped_read_a : assert property ((reg_read_in && reg_addr_in > LANE_CTRL_ADDR) |=>
         reg_rdata_out == 8'h00)
      else $error("unmapped offset reads nonzero");

   gen_reserved_a : assert property ((reg_read_in && reg_addr_in == GEN_CTRL_ADDR) |=>
         reg_rdata_out[7:6] == 2'h0)
      else $error("general reserved bits read one");

   lane_reserved_a : assert property ((reg_read_in && reg_addr_in == LANE_CTRL_ADDR) |=>
         reg_rdata_out[6:4] == 3'h0)
      else $error("lane control reserved bits read one");
endmodule
`default_nettype wire

/* File: core/alt_mode_pkg.sv */
// Shared constants of the alternate-mode switch configuration registers.
// Assumes a byte-wide register port fed by an external serial slave.
`default_nettype none
package alt_mode_pkg;
   // Register offsets
   localparam logic [7:0]  GEN_CTRL_ADDR    = 8'h0A;
   localparam logic [7:0]  LANE01_EQ_ADDR   = 8'h10;
   localparam logic [7:0]  LANE23_EQ_ADDR   = 8'h11;
   localparam logic [7:0]  SNOOP_CAP_ADDR   = 8'h12;
   localparam logic [7:0]  LANE_CTRL_ADDR   = 8'h13;
   // General control layout and reset
   localparam int          GC_CFG_LSB       = 0;
   localparam int          GC_CFG_MSB       = 1;
   localparam int          GC_FLIP_BIT      = 2;
   localparam int          GC_HPD_FORCE_BIT = 3;
   localparam int          GC_EQ_OVR_BIT    = 4;
   localparam int          GC_HPD_SWAP_BIT  = 5;
   localparam logic [1:0]  GEN_CTRL_CFG_RST = 2'h1;
   // Lane configuration select encodings
   localparam logic [1:0]  CFG_ALL_OFF      = 2'h0;
   localparam logic [1:0]  CFG_USB_ONLY     = 2'h1;
   localparam logic [1:0]  CFG_DP_FOUR      = 2'h2;
   localparam logic [1:0]  CFG_DP_TWO_USB   = 2'h3;
   localparam logic [3:0]  MASK_DP_FOUR     = 4'hF;
   localparam logic [3:0]  MASK_DP_TWO      = 4'h3;
   // Snoop capture layout and snooped sink addresses
   localparam int          PWR_LSB          = 5;
   localparam int          PWR_MSB          = 6;
   localparam int          CNT_LSB          = 0;
   localparam int          CNT_MSB          = 4;
   localparam logic [19:0] PWR_STATE_ADDR   = 20'h00600;
   localparam logic [19:0] LANE_COUNT_ADDR  = 20'h00101;
   localparam logic [1:0]  PWR_ACTIVE       = 2'h1;
   // Lane control layout
   localparam int          SNOOP_OFF_BIT    = 7;
   localparam int          LANE_OFF_MSB     = 3;
   // Sizes
   localparam int          LANES            = 4;
   localparam int          EQ_W             = 4;
   localparam logic [1:0]  EQ_STRAP_PAD     = 2'h0;
endpackage
`default_nettype wire

/* File: core/lane_ctl_if.sv */
// Carrier between the register bank and the lane enable decoder.
// Assumes both ends sit on the same clock; the decoder is combinational.
`default_nettype none
interface lane_ctl_if;
   logic [1:0] cfg;
   logic       snoop_off;
   logic [3:0] lane_off;
   logic [1:0] pwr;
   logic [4:0] cnt;
   logic [3:0] lane_en;
   modport owner   (output cfg, snoop_off, lane_off, pwr, cnt, input lane_en);
   modport decoder (input cfg, snoop_off, lane_off, pwr, cnt, output lane_en);
endinterface
`default_nettype wire

/* File: core/lane_enable_decode.sv */
// Per-lane enable decode from configuration, snoop captures and lane disables.
// Assumes its inputs are registered by the owner; output is combinational.
`default_nettype none
module lane_enable_decode
   import alt_mode_pkg::*;
(
   lane_ctl_if.decoder ctl
);
   logic [3:0] avail;

   always_comb begin
      case (ctl.cfg)
         CFG_DP_FOUR:    avail = MASK_DP_FOUR;
         CFG_DP_TWO_USB: avail = MASK_DP_TWO;
         default:        avail = '0;
      endcase
   end

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      localparam logic [4:0] IDX = 5'(i);
      always_comb begin
         if (ctl.snoop_off) begin
            ctl.lane_en[i] = avail[i] & ~ctl.lane_off[i];
         end else begin
            ctl.lane_en[i] = avail[i] & (ctl.pwr == PWR_ACTIVE)
                             & (IDX < ctl.cnt);
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/reg_host_model.sv */
// Host model: single-byte register writes and reads on the byte port.
// Assumes the device samples strobes on the rising clock edge.
`default_nettype none
module reg_host_model (
   // Clock and read data
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   // Register port
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out,
   output logic            write_out,
   output logic            read_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_out  = 8'h00;
      wdata_out = 8'h00;
      write_out = 1'b0;
      read_out  = 1'b0;
   end
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      write_out <= 1'b1;
      @(posedge clk_in);
      write_out <= 1'b0;
      // Released data is inverted so a stale byte is never mistaken for a write
      wdata_out <= ~d;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      read_out <= 1'b1;
      @(posedge clk_in);
      read_out <= 1'b0;
      @(posedge clk_in);
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the alternate-mode configuration registers.
// Assumes the host model owns the register port; snoop and pins are driven here.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import alt_mode_pkg::*;
   logic        clk, rst, wr, rd, snp_wr, hpa, hpb, usb_en, flip, hpd;
   logic [7:0]  addr, wdata, rdata, snp_data;
   logic [19:0] snp_addr;
   logic [1:0]  dstr, sstr, ustr, ss_out, us_out;
   logic [3:0]  lane;
   logic [15:0] eq;
   int          n_errors, checks, cycles;
   alt_mode_switch_config_regs i_alt_mode_switch_config_regs (
      .sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
      .snoop_write_in(snp_wr), .snoop_addr_in(snp_addr), .snoop_data_in(snp_data),
      .display_eq_straps_in(dstr), .superspeed_eq_straps_in(sstr),
      .usb_rx_eq_straps_in(ustr), .hotplug_pin_a_in(hpa), .hotplug_pin_b_in(hpb),
      .dp_lane_en_out(lane), .usb_path_en_out(usb_en),
      .orientation_flip_select_out(flip), .hotplug_input_out(hpd),
      .lane_eq_level_out(eq), .superspeed_eq_straps_out(ss_out),
      .usb_rx_eq_straps_out(us_out));
   reg_host_model i_reg_host_model (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .write_out(wr), .read_out(rd));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      i_reg_host_model.write_reg(a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_reg_host_model.read_reg(a, d);
      check({8'h00, d}, {8'h00, exp});
   endtask
   task automatic snoop(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      snp_wr   <= 1'b1;
      snp_addr <= a;
      snp_data <= d;
      @(posedge clk);
      snp_wr   <= 1'b0;
      snp_data <= ~d;
   endtask
   task automatic t_reset;
      rchk(GEN_CTRL_ADDR, 8'h01);
      check({15'h0, usb_en}, 16'h0001);
      rchk(LANE01_EQ_ADDR, 8'h88);
      check(eq, 16'h8888);
      check({12'h0, ss_out, us_out}, {12'h0, sstr, ustr});
      rchk(SNOOP_CAP_ADDR, 8'h00);
      rchk(LANE_CTRL_ADDR, 8'h00);
      rchk(8'h55, 8'h00);
      wreg(LANE23_EQ_ADDR, 8'h5A);
      rchk(LANE23_EQ_ADDR, 8'h88);
   endtask
   task automatic t_eq;
      wreg(GEN_CTRL_ADDR, 8'hD1);
      rchk(GEN_CTRL_ADDR, 8'h11);
      wreg(LANE01_EQ_ADDR, 8'h5A);
      wreg(LANE23_EQ_ADDR, 8'hC3);
      rchk(LANE01_EQ_ADDR, 8'h5A);
      rchk(LANE23_EQ_ADDR, 8'hC3);
      check(eq, 16'hC35A);
      wreg(GEN_CTRL_ADDR, 8'h01);
      tick(2);
      check(eq, 16'h8888);
   endtask
   task automatic t_cfg;
      logic [4:0] exp [4];
      exp = '{5'h00, 5'h10, 5'h0F, 5'h13};
      wreg(LANE_CTRL_ADDR, 8'h80);
      for (int c = 3; c >= 0; c--) begin
         wreg(GEN_CTRL_ADDR, {6'h00, 2'(c)});
         tick(2);
         check({11'h0, usb_en, lane}, {11'h0, exp[c]});
      end
      wreg(GEN_CTRL_ADDR, 8'h02);
      wreg(LANE_CTRL_ADDR, 8'h85);
      tick(2);
      check({12'h0, lane}, 16'h000A);
      rchk(LANE_CTRL_ADDR, 8'h85);
   endtask
   task automatic t_snoop;
      wreg(LANE_CTRL_ADDR, 8'h00);
      snoop(PWR_STATE_ADDR, 8'h01);
      snoop(LANE_COUNT_ADDR, 8'h02);
      snoop(20'h00102, 8'h1F);
      tick(2);
      check({12'h0, lane}, 16'h0003);
      rchk(SNOOP_CAP_ADDR, 8'h22);
      wreg(SNOOP_CAP_ADDR, 8'hFF);
      rchk(SNOOP_CAP_ADDR, 8'h22);
      snoop(PWR_STATE_ADDR, 8'h02);
      tick(2);
      check({12'h0, lane}, 16'h0000);
      wreg(LANE_CTRL_ADDR, 8'h80);
      tick(2);
      check({12'h0, lane}, 16'h000F);
      wreg(GEN_CTRL_ADDR, 8'h01);
      rchk(SNOOP_CAP_ADDR, 8'h00);
   endtask
   task automatic pins(input logic a, input logic b, input logic exp);
      @(posedge clk);
      hpa <= a;
      hpb <= b;
      tick(2);
      check({15'h0, hpd}, {15'h0, exp});
   endtask
   task automatic t_hotplug;
      pins(1'b1, 1'b0, 1'b1);
      pins(1'b0, 1'b1, 1'b0);
      wreg(GEN_CTRL_ADDR, 8'h09);
      pins(1'b0, 1'b0, 1'b1);
      wreg(GEN_CTRL_ADDR, 8'h21);
      pins(1'b0, 1'b1, 1'b1);
      pins(1'b1, 1'b0, 1'b0);
      wreg(GEN_CTRL_ADDR, 8'h05);
      tick(2);
      check({15'h0, flip}, 16'h0001);
   endtask
   task automatic test_done;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Run is about 130 cycles; the ceiling leaves a wide margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      rst      = 1'b1;
      snp_wr   = 1'b0;
      snp_addr = 20'h00000;
      snp_data = 8'h00;
      dstr     = 2'h2;
      sstr     = 2'h1;
      ustr     = 2'h3;
      hpa      = 1'b0;
      hpb      = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      tick(3);
      t_reset();
      t_eq();
      t_cfg();
      t_snoop();
      t_hotplug();
      test_done();
   end
endmodule
`default_nettype wire
